// ===== pkg/core_sys_ctrl_defs.svh
// Purpose: offsets, field positions, reset values and keys of the system control register pair
// Assumes: byte addresses on an 8-bit register port, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef CORE_SYS_CTRL_DEFS_SVH
`define CORE_SYS_CTRL_DEFS_SVH

`define REG_ADDR_W        8
`define REG_DATA_W        32
`define CTRL_OFFSET       8'h0c
`define SLEEP_CTRL_OFFSET 8'h10

// interrupt/reset control word
`define KEY_MSB           31
`define KEY_LSB           16
`define WRITE_KEY         16'h05fa
`define KEY_STATUS        16'hfa05
`define ENDIAN_BIT        15
`define LITTLE_ENDIAN     1'h0
`define SPLIT_MSB         10
`define SPLIT_LSB         8
`define SPLIT_RESET       3'h0
`define RESET_REQ_BIT     2
`define DBG_CLR_BIT       1
`define DBG_RST_BIT       0

// sleep control word
`define ANY_PEND_BIT      4
`define DEPTH_BIT         2
`define IDLE_RET_BIT      1

`define PRIO_W            8
`define SPLIT_W           3

`endif

// ===== pkg/core_sys_ctrl_pkg.sv
// Purpose: shared types of the system control register pair
// Assumes: constants come from core_sys_ctrl_defs.svh
// Notes:   no codes are given to the state enum
package core_sys_ctrl_pkg;

  typedef enum logic [1:0] {
    st_run,
    st_wait_event,
    st_sleep
  } power_state_e;

  typedef logic [2:0] split_t;

endpackage

// ===== pkg/prio_split_if.sv
// Purpose: carries priorities and the split select between the register bank and the splitter
// Assumes: lower priority value means more urgent
// Notes:   combinational path; the requester registers what it needs
`timescale 1ns/10ps
interface prio_split_if #(parameter int PRIO_W = 8, parameter int SPLIT_W = 3);
  logic [SPLIT_W-1:0] split;
  logic               pending_valid;
  logic [PRIO_W-1:0]  pending_prio;
  logic [PRIO_W-1:0]  active_prio;
  logic               preempt;
  logic [PRIO_W-1:0]  pending_group;

  modport requester (
    output split,
    output pending_valid,
    output pending_prio,
    output active_prio,
    input  preempt,
    input  pending_group
  );

  modport splitter (
    input  split,
    input  pending_valid,
    input  pending_prio,
    input  active_prio,
    output preempt,
    output pending_group
  );
endinterface

// ===== design/priority_split.sv
// Purpose: splits priorities into group and subpriority and decides preemption
// Assumes: split value n makes bits n..0 subpriority
// Notes:   pure combinational; the caller registers the result
`timescale 1ns/10ps
module priority_split #(
  parameter int PRIO_W  = 8,
  parameter int SPLIT_W = 3
) (
  prio_split_if.splitter bus
);

  // the split can only name bit positions that exist in the priority
  if (PRIO_W < 2 || (1 << SPLIT_W) > PRIO_W)
  begin : g_bad_width
    $error("priority_split: PRIO_W must cover every split position");
  end

  // keep only bits strictly above the split point; split of top bit leaves nothing
  function automatic logic [PRIO_W-1:0] group_of(input logic [PRIO_W-1:0] prio,
                                                  input logic [SPLIT_W-1:0] split);
    logic [PRIO_W-1:0] kept;
    kept = '0;
    for (int i = 0; i < PRIO_W; i++)
    begin
      if (i > int'(split))
        kept[i] = prio[i];
    end
    return kept;
  endfunction

  logic [PRIO_W-1:0] active_group;

  // group part of both sides; subpriority is masked away
  assign bus.pending_group = group_of(bus.pending_prio, bus.split); // [RULE_05]
  assign active_group      = group_of(bus.active_prio, bus.split); // [RULE_05]

  // only a strictly more urgent group preempts
  assign bus.preempt = bus.pending_valid && (bus.pending_group < active_group); // [RULE_06]

endmodule

// ===== design/core_system_control_regs.sv
// Purpose: interrupt/reset control and sleep control registers of the core
// Assumes: one core clock; the outer reset controller drives our reset when it acts
// Notes:   register port is plain strobes, read data valid one cycle after the read strobe
//
// How it works
// [RULE_01] drop whole control write without correct key
// [RULE_02] key field reads fixed status constant
// [RULE_03] byte-order bit reads zero, little-endian
// [RULE_04] three-bit writable priority split select
// [RULE_05] bits above split are group priority
// [RULE_06] preemption compares group priority only
// [RULE_07] keyed reset-bit write raises reset request
// [RULE_08] outer system resets all except debug
// [RULE_09] debug bits read zero, writes ignored
// [RULE_10] any-pending bit widens wake to disabled interrupts
// [RULE_11] pending event wakes waiter or gets latched
// [RULE_12] send-event and external event also wake
// [RULE_13] depth bit picks sleep or deep sleep
// [RULE_14] idle after handler return when bit set
// [RULE_15] reset request held until outer reset
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`include "core_sys_ctrl_defs.svh"
`timescale 1ns/10ps
module core_system_control_regs
  import core_sys_ctrl_pkg::*;
#(
  parameter int PRIO_W  = `PRIO_W,
  parameter int SPLIT_W = `SPLIT_W
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  // register port
  input  wire logic [`REG_ADDR_W-1:0] reg_addr,
  input  wire logic [`REG_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output logic      [`REG_DATA_W-1:0] reg_rdata,
  // toward the outer reset and power controller
  output logic                        outer_reset_request,
  output logic                        core_waiting,
  output logic                        sleep_active,
  output logic                        deep_sleep_active,
  output logic                        wake_pulse,
  // core execution status
  input  wire logic                   wait_for_event_instr,
  input  wire logic                   send_event_instr,
  input  wire logic                   handler_return_to_thread,
  input  wire logic                   irq_pending_enabled,
  input  wire logic                   irq_pending_any,
  input  wire logic                   event_in_pin,
  // preemption check
  input  wire logic                   pending_valid,
  input  wire logic [PRIO_W-1:0]      pending_priority,
  input  wire logic [PRIO_W-1:0]      active_priority,
  output logic                        preempt,
  output logic      [PRIO_W-1:0]      pending_group_priority
);

  // split select must fit the package type and its field
  // split_t is fixed at three bits, so no other width can work
  if (SPLIT_W != (`SPLIT_MSB - `SPLIT_LSB + 1))
  begin : g_bad_split
    $error("core_system_control_regs: SPLIT_W must match the split field");
  end

  // address decode, shared by the write and the read path
  // plain equality: no byte lanes, so a misaligned address just misses
  function automatic logic hits(input logic [`REG_ADDR_W-1:0] addr,
                                input logic [`REG_ADDR_W-1:0] offset);
    return addr == offset;
  endfunction

  // decode and write qualifiers
  logic                 ctrl_hit;
  logic                 sleep_hit;
  logic                 key_ok;
  logic                 ctrl_write_ok;
  logic                 sleep_write;

  // software-visible fields
  split_t               priority_split_select;
  logic                 wake_on_any_pending;
  logic                 low_power_depth_select;
  logic                 idle_after_handler_return;

  // event pin synchroniser and filtered level
  logic                 ev_s1;
  logic                 ev_s2;
  logic                 ev_s3;
  logic                 ev_level;
  logic                 ext_event;

  // wake sources and the remembered event
  logic                 wake_source;
  logic                 wake_source_d;
  logic                 pend_event;
  logic                 any_event;
  logic                 event_latch;

  // power sequencing
  power_state_e         state;
  power_state_e         next_state;
  logic                 consume_event;

  // read path words
  logic [`REG_DATA_W-1:0] next_rdata;
  logic [`REG_DATA_W-1:0] ctrl_word;
  logic [`REG_DATA_W-1:0] sleep_word;

  // carrier toward the group splitter
  prio_split_if #(.PRIO_W(PRIO_W), .SPLIT_W(SPLIT_W)) u_prio_if ();

  // decode of the two words; misaligned or other addresses hit nothing
  assign ctrl_hit  = hits(reg_addr, `CTRL_OFFSET);
  assign sleep_hit = hits(reg_addr, `SLEEP_CTRL_OFFSET);

  // the key guards every field of the control word, not only the reset bit
  // a wrong key leaves the split select and the request untouched
  assign key_ok        = reg_wdata[`KEY_MSB:`KEY_LSB] == `WRITE_KEY; // [RULE_01]
  assign ctrl_write_ok = reg_write && ctrl_hit && key_ok; // [RULE_01]
  assign sleep_write   = reg_write && sleep_hit;

  // priority split select, only a keyed write may change it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      priority_split_select <= `SPLIT_RESET;
    else if (ctrl_write_ok)
      priority_split_select <= reg_wdata[`SPLIT_MSB:`SPLIT_LSB]; // [RULE_04]
  end

  // reset request: once raised it stays up, only the outer reset drops it,
  // so a slow reset controller can never miss a one-cycle request
  // the outer controller is expected to spare the debug logic
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      outer_reset_request <= 1'b0;
    else if (ctrl_write_ok && reg_wdata[`RESET_REQ_BIT])
      outer_reset_request <= 1'b1; // [RULE_07] [RULE_15] [RULE_08]
  end

  // sleep control bits, plain read/write without a key
  // trade-off: no key here, so a stray write can change sleep depth
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wake_on_any_pending       <= 1'b0;
      low_power_depth_select    <= 1'b0;
      idle_after_handler_return <= 1'b0;
    end
    else if (sleep_write)
    begin
      wake_on_any_pending       <= reg_wdata[`ANY_PEND_BIT];
      low_power_depth_select    <= reg_wdata[`DEPTH_BIT];
      idle_after_handler_return <= reg_wdata[`IDLE_RET_BIT];
    end
  end

  // read images; write-only and reserved bits read as zero
  // the request bit has no read-back flop, it always reads zero
  always_comb
  begin
    ctrl_word                         = '0;
    ctrl_word[`KEY_MSB:`KEY_LSB]      = `KEY_STATUS; // [RULE_02]
    ctrl_word[`ENDIAN_BIT]            = `LITTLE_ENDIAN; // [RULE_03]
    ctrl_word[`SPLIT_MSB:`SPLIT_LSB]  = priority_split_select; // [RULE_04]
    ctrl_word[`RESET_REQ_BIT]         = 1'b0; // [RULE_07]
    ctrl_word[`DBG_CLR_BIT]           = 1'b0; // [RULE_09]
    ctrl_word[`DBG_RST_BIT]           = 1'b0; // [RULE_09]
  end

  // sleep word image; only three bits are backed by flops
  always_comb
  begin
    sleep_word                = '0;
    sleep_word[`ANY_PEND_BIT] = wake_on_any_pending;
    sleep_word[`DEPTH_BIT]    = low_power_depth_select;
    sleep_word[`IDLE_RET_BIT] = idle_after_handler_return;
  end

  // read mux; unmapped reads and idle cycles give zero
  // limitation: no error reply, an unmapped read looks like zero
  always_comb
  begin
    next_rdata = '0;
    if (reg_read && ctrl_hit)
      next_rdata = ctrl_word;
    else if (reg_read && sleep_hit)
      next_rdata = sleep_word;
  end

  // read data stands only in the cycle after the strobe
  // idle cycles clear it, so a stale word never shows twice
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= '0;
    else
      reg_rdata <= next_rdata;
  end

  // external event pin: three flops, a change counts once the last two agree
  // only the second flop reads the first, which may go metastable
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_s3 <= 1'b0;
    end
    else
    begin
      ev_s1 <= event_in_pin;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end

  // filtered pin level; its rising edge is one event
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ev_level <= 1'b0;
    else if (ev_s2 == ev_s3)
      ev_level <= ev_s3;
  end

  // one pulse per filtered rising edge; short glitches never count
  assign ext_event = (ev_s2 == ev_s3) && ev_s3 && !ev_level; // [RULE_12]

  // disabled interrupts count only when the any-pending bit is set
  assign wake_source = irq_pending_enabled || (wake_on_any_pending && irq_pending_any); // [RULE_10]

  // previous wake level: a source that stays pending is one event
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      wake_source_d <= 1'b0;
    else
      wake_source_d <= wake_source;
  end

  // a newly pending wake source is an event as well
  assign pend_event = wake_source && !wake_source_d; // [RULE_11]
  assign any_event  = pend_event || send_event_instr || ext_event; // [RULE_11] [RULE_12]

  // event latch is used up by a wait that completes; a new event in the
  // same cycle wins, so it is never lost
  // inside the wait state an event ends the wait instead
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      event_latch <= 1'b0;
    else if (any_event && state != st_wait_event)
      event_latch <= 1'b1; // [RULE_11]
    else if (consume_event)
      event_latch <= 1'b0;
  end

  // power state sequencing
  always_comb
  begin
    next_state    = state;
    consume_event = 1'b0;
    case (state)
      st_run:
      begin
        if (wait_for_event_instr && event_latch)
          consume_event = 1'b1; // [RULE_11]
        else if (wait_for_event_instr)
          next_state = st_wait_event;
        else if (handler_return_to_thread && idle_after_handler_return)
          next_state = st_sleep; // [RULE_14]
      end
      st_wait_event:
      begin
        // a level still pending also ends the wait, so a source
        // that rose in the cycle of entry is not lost
        if (any_event || wake_source)
          next_state = st_run; // [RULE_11] [RULE_12]
      end
      st_sleep:
      begin
        // sleep ignores send-event and the pin; only interrupts end it
        if (wake_source)
          next_state = st_run; // [RULE_10]
      end
      // unreachable encodings fall back to run
      default:
        next_state = st_run;
    endcase
  end

  // state register; reset always lands in run
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state <= st_run;
    else
      state <= next_state;
  end

  // status outputs registered from the next state so they line up with it;
  // the depth bit is sampled at entry and on every cycle of the stay
  // wake_pulse is one cycle wide since state is run on the next edge
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      core_waiting      <= 1'b0;
      sleep_active      <= 1'b0;
      deep_sleep_active <= 1'b0;
      wake_pulse        <= 1'b0;
    end
    else
    begin
      core_waiting      <= next_state != st_run;
      sleep_active      <= next_state != st_run && !low_power_depth_select; // [RULE_13]
      deep_sleep_active <= next_state != st_run && low_power_depth_select; // [RULE_13]
      wake_pulse        <= state != st_run && next_state == st_run;
    end
  end

  // priority split request toward the splitter
  assign u_prio_if.split         = priority_split_select;
  assign u_prio_if.pending_valid = pending_valid;
  assign u_prio_if.pending_prio  = pending_priority;
  assign u_prio_if.active_prio   = active_priority;

  priority_split #(
    .PRIO_W  (PRIO_W),
    .SPLIT_W (SPLIT_W)
  ) u_split (
    .bus (u_prio_if.splitter)
  );

  // one cycle of latency keeps the splitter off the output path
  // a caller needing a same-cycle answer must use the splitter itself
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      preempt                <= 1'b0;
      pending_group_priority <= '0;
    end
    else
    begin
      preempt                <= u_prio_if.preempt; // [RULE_06]
      pending_group_priority <= u_prio_if.pending_group; // [RULE_05]
    end
  end

endmodule

// ===== dv/core_system_control_regs_checker.sv
// Purpose: port-level checks of the system control register pair
// Assumes: one clock, reset asynchronous and active high
// Notes:   the split select is shadowed from keyed writes
`include "core_sys_ctrl_defs.svh"
`timescale 1ns/10ps
module core_system_control_regs_checker #(
  parameter int PRIO_W  = 8,
  parameter int SPLIT_W = 3
) (
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic [`REG_ADDR_W-1:0] reg_addr,
  input wire logic [`REG_DATA_W-1:0] reg_wdata,
  input wire logic                   reg_write,
  input wire logic                   reg_read,
  input wire logic [`REG_DATA_W-1:0] reg_rdata,
  input wire logic                   outer_reset_request,
  input wire logic                   core_waiting,
  input wire logic                   sleep_active,
  input wire logic                   deep_sleep_active,
  input wire logic                   wake_pulse,
  input wire logic                   pending_valid,
  input wire logic [PRIO_W-1:0]      pending_priority,
  input wire logic [PRIO_W-1:0]      active_priority,
  input wire logic                   preempt,
  input wire logic [PRIO_W-1:0]      pending_group_priority
);
  logic [SPLIT_W-1:0] split_sh;
  logic [PRIO_W-1:0]  gmask;
  logic               key_wr;
  logic               req_wr;
  logic               exp_pre;

  // decoded writes and the group mask; split 7 leaves no group bits
  assign key_wr  = reg_write && reg_addr == `CTRL_OFFSET && reg_wdata[`KEY_MSB:`KEY_LSB] == `WRITE_KEY;
  assign req_wr  = key_wr && reg_wdata[`RESET_REQ_BIT];
  assign gmask   = {PRIO_W{1'b1}} << (int'(split_sh) + 1);
  assign exp_pre = pending_valid && (pending_priority & gmask) < (active_priority & gmask);

  // shadow moves on the same edge as the real field
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      split_sh <= '0;
    else if (key_wr)
      split_sh <= reg_wdata[`SPLIT_MSB:`SPLIT_LSB];
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_ctrl_readout: assert property (reg_read && reg_addr == `CTRL_OFFSET |=>
    reg_rdata[31:11] == {`KEY_STATUS, 5'h00} && reg_rdata[7:0] == 8'h00) else $error("control word readout wrong");
  a_split_readback: assert property (key_wr ##1 reg_read && reg_addr == `CTRL_OFFSET |=>
    reg_rdata[`SPLIT_MSB:`SPLIT_LSB] == $past(reg_wdata[`SPLIT_MSB:`SPLIT_LSB], 2)) else $error("split not kept");
  a_req_on_key: assert property (req_wr |=> outer_reset_request) else $error("reset request missing");
  a_req_held: assert property (outer_reset_request |=> outer_reset_request) else $error("request dropped");
  a_req_cause: assert property ($rose(outer_reset_request) |-> $past(req_wr)) else $error("request w/o key");
  a_group_value: assert property (1'b1 |=>
    pending_group_priority == ($past(pending_priority) & $past(gmask))) else $error("group priority wrong");
  a_preempt_group: assert property (1'b1 |=> preempt == $past(exp_pre)) else $error("preempt wrong");
  a_wake_pulse: assert property (wake_pulse |-> $past(core_waiting) && !core_waiting ##1 !wake_pulse)
    else $error("wake pulse misplaced");
  a_depth_excl: assert property ((sleep_active || deep_sleep_active) == core_waiting &&
    !(sleep_active && deep_sleep_active)) else $error("sleep depth outputs wrong");

  c_readback: cover property (key_wr ##1 reg_read);
  c_request: cover property ($rose(outer_reset_request));
  c_wake: cover property (wake_pulse);
  c_preempt: cover property (preempt);
endmodule

bind core_system_control_regs core_system_control_regs_checker #(.PRIO_W(PRIO_W), .SPLIT_W(SPLIT_W)) checker_inst (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .outer_reset_request(outer_reset_request),
  .core_waiting(core_waiting), .sleep_active(sleep_active), .deep_sleep_active(deep_sleep_active),
  .wake_pulse(wake_pulse), .pending_valid(pending_valid), .pending_priority(pending_priority),
  .active_priority(active_priority), .preempt(preempt), .pending_group_priority(pending_group_priority));

// ===== dv/outer_reset_model.sv
// Purpose: outer reset controller answering the core's reset request
// Assumes: request is a level held until our reset lands
// Notes:   own power-on reset, so its pulse is not cut by itself
`timescale 1ns/10ps
module outer_reset_model (
  input  wire logic       clk,
  input  wire logic       por,
  input  wire logic [7:0] delay_cycles,
  input  wire logic       outer_reset_request,
  output logic            sys_reset
);
  logic [7:0] count;

  // wait the chosen delay, then reset the core for four cycles; debug side not modelled
  always_ff @(posedge clk or posedge por)
  begin
    if (por)
    begin
      count     <= '0;
      sys_reset <= 1'b0;
    end
    else if (sys_reset)
    begin
      count     <= (count == 8'h03) ? 8'h00 : count + 8'h01;
      sys_reset <= count != 8'h03;
    end
    else if (outer_reset_request && count >= delay_cycles)
    begin
      count     <= '0;
      sys_reset <= 1'b1;
    end
    else
      count <= outer_reset_request ? count + 8'h01 : 8'h00;
  end
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench of the system control register pair
// Assumes: 200 MHz clock, reset also driven by the outer reset model
// Notes:   table rows cover plain accesses, hand tests the rest
`include "core_sys_ctrl_defs.svh"
`timescale 1ns/10ps
module tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic        clk, por, reset, sys_reset, reg_write, reg_read, outer_reset_request;
  logic        core_waiting, sleep_active, deep_sleep_active, wake_pulse;
  logic        irq_en, irq_any, pin, pvalid, preempt;
  logic [2:0]  core_ev;
  logic [7:0]  reg_addr, delay_cycles, ppri, apri, pgroup, gmask;
  logic [31:0] reg_wdata, reg_rdata;
  int          err_total, tests_run, n;
  row_s        rows [8] = '{'{8'h0c, 32'h05fa_0300, 32'hfa05_0300}, '{8'h0c, 32'h05fa_f8f8, 32'hfa05_0000},
    '{8'h0c, 32'h05fa_0700, 32'hfa05_0700}, '{8'h0c, 32'h1234_0500, 32'hfa05_0700},
    '{8'h0c, 32'hfa05_0200, 32'hfa05_0700}, '{8'h10, 32'hffff_ffff, 32'h0000_0016},
    '{8'h20, 32'hffff_ffff, 32'h0}, '{8'h10, 32'h0, 32'h0}};
  logic [7:0]  dly [2] = '{8'h01, 8'h14};

  assign reset = por | sys_reset;

  core_system_control_regs core_system_control_regs_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .outer_reset_request(outer_reset_request), .core_waiting(core_waiting), .sleep_active(sleep_active),
    .deep_sleep_active(deep_sleep_active), .wake_pulse(wake_pulse), .wait_for_event_instr(core_ev[0]),
    .send_event_instr(core_ev[1]), .handler_return_to_thread(core_ev[2]), .irq_pending_enabled(irq_en),
    .irq_pending_any(irq_any), .event_in_pin(pin), .pending_valid(pvalid), .pending_priority(ppri),
    .active_priority(apri), .preempt(preempt), .pending_group_priority(pgroup));
  outer_reset_model outer_reset_model_inst (.clk(clk), .por(por), .delay_cycles(delay_cycles),
    .outer_reset_request(outer_reset_request), .sys_reset(sys_reset));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // the strobe is left high; the next access or idle lowers it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_read  <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask

  task automatic idle;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clk);
    reg_read  <= 1'b1;
    reg_write <= 1'b0;
    reg_addr  <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(name, exp, reg_rdata);
  endtask

  // one-cycle pulse on the core status inputs, states settle one cycle later
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    core_ev <= v;
    @(posedge clk);
    core_ev <= 3'h0;
    #1;
  endtask

  task automatic wait_wake(input string name);
    for (n = 0; n < 16 && core_waiting !== 1'b0; n++)
      @(negedge clk);
    #1 chk(name, 32'h0, {31'h0, core_waiting});
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a hang costs a mismatch and still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  initial
  begin
    {por, reg_write, reg_read, irq_en, irq_any, pin, pvalid, core_ev} = 10'h200;
    {reg_addr, delay_cycles, ppri, apri, reg_wdata} = '0;
    err_total = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    por <= 1'b0;
    #1 chk("outputs in reset", 32'h0, {outer_reset_request, core_waiting, wake_pulse, preempt, pgroup});
    rd(`CTRL_OFFSET, 32'hfa05_0000, "control reset value");
    rd(`SLEEP_CTRL_OFFSET, 32'h0, "sleep reset value");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "table read");
    end
    $display("test table done");
    // group and preemption for every split value
    pvalid <= 1'b1;
    ppri   <= 8'h3c;
    apri   <= 8'h40;
    for (int s = 0; s < 8; s++)
    begin
      wr(`CTRL_OFFSET, {`WRITE_KEY, 5'h00, 3'(s), 8'h00});
      idle();
      @(posedge clk);
      gmask = 8'hff << (s + 1);
      #1 chk("group", {24'h0, ppri & gmask}, {24'h0, pgroup});
      chk("preempt", {31'h0, (ppri & gmask) < (apri & gmask)}, {31'h0, preempt});
    end
    wr(`CTRL_OFFSET, {`WRITE_KEY, 16'h0000});
    pvalid <= 1'b0;
    idle();
    @(posedge clk);
    #1 chk("no offer", 32'h0, {31'h0, preempt});
    $display("test preempt done");
    // wait state, send-event wake and the latched event
    pulse(3'h1);
    chk("waiting", 32'h3, {30'h0, core_waiting, sleep_active});
    pulse(3'h2);
    chk("woken", 32'h1, {30'h0, core_waiting, wake_pulse});
    pulse(3'h2);
    pulse(3'h1);
    chk("latched", 32'h0, {31'h0, core_waiting});
    wr(`SLEEP_CTRL_OFFSET, 32'h0000_0004);
    idle();
    pulse(3'h1);
    chk("deep", 32'h5, {29'h0, core_waiting, sleep_active, deep_sleep_active});
    irq_any <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("disabled irq ignored", 32'h1, {31'h0, core_waiting});
    wr(`SLEEP_CTRL_OFFSET, 32'h0000_0014);
    idle();
    wait_wake("any pending wakes");
    irq_any <= 1'b0;
    pulse(3'h1);
    pin <= 1'b1;
    wait_wake("pin event");
    pin <= 1'b0;
    wr(`SLEEP_CTRL_OFFSET, 32'h0000_0002);
    idle();
    pulse(3'h4);
    chk("idle after return", 32'h3, {30'h0, core_waiting, sleep_active});
    irq_en <= 1'b1;
    wait_wake("enabled irq wakes");
    irq_en <= 1'b0;
    wr(`SLEEP_CTRL_OFFSET, 32'h0);
    idle();
    pulse(3'h4);
    chk("stay awake", 32'h0, {31'h0, core_waiting});
    $display("test power done");
    // reset request, refused without key, then answered fast and slow
    wr(`CTRL_OFFSET, 32'h1234_0004);
    rd(`CTRL_OFFSET, 32'hfa05_0000, "unkeyed reset bit");
    chk("no request", 32'h0, {31'h0, outer_reset_request});
    foreach (dly[i])
    begin
      delay_cycles <= dly[i];
      wr(`CTRL_OFFSET, 32'h05fa_0504);
      rd(`CTRL_OFFSET, 32'hfa05_0500, "request bit reads zero");
      chk("request", 32'h1, {31'h0, outer_reset_request});
      for (n = 0; n < 40 && outer_reset_request !== 1'b0; n++)
        @(negedge clk);
      chk("held cycles", 32'h1, {31'h0, n >= int'(dly[i]) && n < 40});
      for (n = 0; n < 10 && reset !== 1'b0; n++)
        @(negedge clk);
      chk("reset released", 32'h0, {31'h0, reset});
      rd(`CTRL_OFFSET, 32'hfa05_0000, "split after reset");
    end
    $display("test reset request done");
    end_of_test();
  end
endmodule
